/* File: pkg/asm_pkg.sv */
package asm_pkg;

   localparam int SMP_W   = 10;
   localparam int MAG_W   = 13;
   localparam int POW_W   = 11;
   localparam int RES_W   = 20;
   localparam int PER_W   = 24;
   localparam int EST_F   = 27;
   localparam int EST_W   = SMP_W + EST_F;
   localparam int FRAME_W = 6 * RES_W;

   localparam logic [8:0] ADDR_UT_LO  = 9'h106;
   localparam logic [8:0] ADDR_UT_HI  = 9'h107;
   localparam logic [8:0] ADDR_DCC    = 9'h10c;
   localparam logic [8:0] ADDR_OFSA_L = 9'h10d;
   localparam logic [8:0] ADDR_OFSA_H = 9'h10e;
   localparam logic [8:0] ADDR_OFSB_L = 9'h10f;
   localparam logic [8:0] ADDR_OFSB_H = 9'h110;
   localparam logic [8:0] ADDR_SSC    = 9'h111;
   localparam logic [8:0] ADDR_MC     = 9'h112;
   localparam logic [8:0] ADDR_PER0   = 9'h113;
   localparam logic [8:0] ADDR_PER1   = 9'h114;
   localparam logic [8:0] ADDR_PER2   = 9'h115;
   localparam logic [8:0] ADDR_RESA0  = 9'h116;
   localparam logic [8:0] ADDR_RESA1  = 9'h117;
   localparam logic [8:0] ADDR_RESA2  = 9'h118;
   localparam logic [8:0] ADDR_RESB0  = 9'h119;
   localparam logic [8:0] ADDR_RESB1  = 9'h11a;
   localparam logic [8:0] ADDR_RESB2  = 9'h11b;

   localparam int MC_EN     = 0;
   localparam int MC_MODE   = 1;
   localparam int MC_CPLX   = 3;
   localparam int SC_EN     = 0;
   localparam int SC_DIV    = 1;
   localparam int SC_RMS    = 3;
   localparam int SC_PK     = 4;
   localparam int SC_THR    = 5;
   localparam int SC_SLEEP  = 6;
   localparam int DC_SM     = 0;
   localparam int DC_PATH   = 1;
   localparam int DC_BW     = 2;
   localparam int DC_FRZ    = 6;

   localparam logic [1:0] MODE_RMS   = 2'h0;
   localparam logic [1:0] MODE_PK    = 2'h1;
   localparam logic [3:0] BW_MAX     = 4'hd;
   localparam logic [7:0] REG_RST    = 8'h00;
   localparam logic [7:0] PER0_RST   = 8'h80;
   localparam logic [7:0] UT_HI_MASK = 8'h1f;

   typedef struct packed {
      logic [RES_W-1:0] result_magnitude;
      logic [RES_W-1:0] pk;
      logic [RES_W-1:0] thr;
   } asm_result_s;

   typedef struct packed {
      asm_result_s a;
      asm_result_s b;
   } asm_frame_s;

   typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_SEND} asm_tx_e;

endpackage : asm_pkg

/* File: src/asm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - magnitude integration runs when mode bits are 00 or rms serial enable is set
// - entering a mode loads the period into the down-counter and counting starts
// - each sample power, reduced to 11 bits, adds into a 24-bit accumulator
// - at count one: square root to result, reload counter, accumulator restarts
// - the magnitude result is a 20-bit fixed-point value
// - threshold counting runs when upper mode bit is set or its serial enable
// - threshold counting compares against the 13-bit fine upper threshold
// - each sample above the threshold adds one to the internal count
// - at count one the count moves to the result and is cleared
// - bit 0 of monitor control enables the three measurements, cleared at reset; correction and data path run regardless
// - complex mode with mode 00: channel A reports root of I^2 plus Q^2
// - correction bandwidth code in bits 5..2, codes 14 and 15 act as 13
// - each channel's 10-bit correction value is readable in a register pair; in complex mode A's pair shows result bits 19..10
// - freeze holds the correction but keeps applying it
// - bit 0 corrects monitor input, bit 1 corrects the output data path
// - the serial port is master and drives clock, sync and data
// - serial clock is 1/2, 1/4 or 1/8 of core clock; outputs move on its rise
// - with sleep set the serial clock stays low while nothing is sent
// - a frame opens with a sync, path A results first, then path B
// - data goes out msb first from the first rising edge after the sync
// - within a path: magnitude, then peak, then threshold count
// - peak detection runs when the mode bits are 01
// - every rising sync input restarts the measurement period
module asm_monitor #(
   parameter int BUF_DEPTH = 2
) (
   input  wire logic                         core_clk,
   input  wire logic                         resetn,
   input  wire logic signed [asm_pkg::SMP_W-1:0] sample_a,
   input  wire logic signed [asm_pkg::SMP_W-1:0] sample_b,
   input  wire logic                         sync_in,
   input  wire logic                         reg_wr_en,
   input  wire logic [8:0]                   reg_addr,
   input  wire logic [7:0]                   reg_wdata,
   output logic [7:0]                        reg_rdata,
   output logic signed [asm_pkg::SMP_W-1:0]  data_out_a,
   output logic signed [asm_pkg::SMP_W-1:0]  data_out_b,
   output logic                              monitor_serial_clock,
   output logic                              monitor_frame_sync,
   output logic                              monitor_serial_out
);
   import asm_pkg::*;

   localparam int PW = $clog2(BUF_DEPTH);

   if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("BUF_DEPTH must be a power of two, at least 2");
   end

   function automatic logic [MAG_W-1:0] mag_of(input logic signed [SMP_W-1:0] s);
      logic [SMP_W-1:0] a;
      a = s[SMP_W-1] ? SMP_W'(-s) : SMP_W'(s);
      return {a, 3'h0};
   endfunction : mag_of

   function automatic logic [POW_W-1:0] pow_of(input logic [MAG_W-1:0] m);
      logic [25:0] p;
      p = 26'(m) * 26'(m);
      return p[24:14];
   endfunction : pow_of

   function automatic logic [11:0] isqrt(input logic [PER_W-1:0] v);
      logic [11:0] r;
      logic [11:0] c;
      r = 12'h000;
      for (int i = 11; i >= 0; i--) begin
         c = r | (12'h001 << i);
         if ((24'(c) * 24'(c)) <= v) begin
            r = c;
         end
      end
      return r;
   endfunction : isqrt

   function automatic logic signed [SMP_W-1:0] sat_of(input logic signed [SMP_W:0] d);
      if (d > 11'sh1ff) begin
         return 10'sh1ff;
      end
      if (d < -11'sh200) begin
         return 10'sh200;
      end
      return d[SMP_W-1:0];
   endfunction : sat_of

   function automatic logic [RES_W-1:0] pick(input asm_result_s r, input logic [1:0] m);
      return (m == MODE_RMS) ? r.result_magnitude : ((m == MODE_PK) ? r.pk : r.thr);
   endfunction : pick

   // packs enabled fields msb-aligned: A mag, pk, thr, then B mag, pk, thr
   function automatic logic [FRAME_W-1:0] pack(input asm_frame_s f, input logic [2:0] en);
      logic [FRAME_W-1:0] s;
      logic [RES_W-1:0]   fld [6];
      int                 n;
      s = '0;
      n = 0;
      fld = '{f.a.result_magnitude, f.a.pk, f.a.thr, f.b.result_magnitude, f.b.pk, f.b.thr};
      for (int i = 0; i < 6; i++) begin
         if (en[2 - (i % 3)]) begin
            s = {s[FRAME_W-RES_W-1:0], fld[i]};
            n = n + 1;
         end
      end
      return s << (RES_W * (6 - n));
   endfunction : pack

   // register file, written straight from the register port
   logic [7:0] ut_lo_reg, ut_hi_reg, dcc_reg, ssc_reg, mc_reg, per0_reg, per1_reg, per2_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ut_lo_reg <= REG_RST;
         ut_hi_reg <= REG_RST;
         dcc_reg   <= REG_RST;
         ssc_reg   <= REG_RST;
         mc_reg    <= REG_RST;
         per0_reg  <= PER0_RST;
         per1_reg  <= REG_RST;
         per2_reg  <= REG_RST;
      end else if (reg_wr_en) begin
         case (reg_addr)
            ADDR_UT_LO: ut_lo_reg <= reg_wdata;
            ADDR_UT_HI: ut_hi_reg <= reg_wdata & UT_HI_MASK;
            ADDR_DCC:   dcc_reg   <= reg_wdata;
            ADDR_SSC:   ssc_reg   <= reg_wdata;
            ADDR_MC:    mc_reg    <= reg_wdata;
            ADDR_PER0:  per0_reg  <= reg_wdata;
            ADDR_PER1:  per1_reg  <= reg_wdata;
            ADDR_PER2:  per2_reg  <= reg_wdata;
            default:    ;
         endcase
      end
   end

   wire             mon_en    = mc_reg[MC_EN];
   wire [1:0]       mode      = mc_reg[MC_MODE +: 2];
   wire             cplx      = mc_reg[MC_CPLX] && (mode == MODE_RMS);
   wire             rms_act   = mon_en && (mode == MODE_RMS || ssc_reg[SC_RMS]);
   wire             pk_act    = mon_en && (mode == MODE_PK || ssc_reg[SC_PK]);
   wire             thr_act   = mon_en && (mode[1] || ssc_reg[SC_THR]);
   wire             run       = rms_act || pk_act || thr_act;
   wire [PER_W-1:0] period    = {per2_reg, per1_reg, per0_reg};
   wire [MAG_W-1:0] threshold = {ut_hi_reg[4:0], ut_lo_reg};
   wire [3:0]       bw_code   = dcc_reg[DC_BW +: 4];
   wire [3:0]       kc        = (bw_code > BW_MAX) ? BW_MAX : bw_code;
   wire             frz       = dcc_reg[DC_FRZ];
   wire [2:0]       fld_en    = {ssc_reg[SC_RMS], ssc_reg[SC_PK], ssc_reg[SC_THR]};
   wire             ser_on    = ssc_reg[SC_EN] && (fld_en != 3'h0);

   // sync pin: first flop feeds only the second
   logic sync_m_reg, sync_s_reg, sync_d_reg, run_d_reg;
   logic [2:0] act_d_reg;
   logic [PER_W-1:0] per_cnt_reg;

   // a mode switched on while another runs restarts the period as well
   wire [2:0] act_vec   = {rms_act, pk_act, thr_act};
   wire       sync_rise = sync_s_reg && !sync_d_reg;
   wire       restart   = (|(act_vec & ~act_d_reg)) || (run && sync_rise);
   wire capture   = run && !restart && (per_cnt_reg == 24'h000001);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync_m_reg  <= 1'b0;
         sync_s_reg  <= 1'b0;
         sync_d_reg  <= 1'b0;
         run_d_reg   <= 1'b0;
         act_d_reg   <= 3'h0;
         per_cnt_reg <= '0;
      end else begin
         sync_m_reg <= sync_in;
         sync_s_reg <= sync_m_reg;
         sync_d_reg <= sync_s_reg;
         run_d_reg  <= run;
         act_d_reg  <= act_vec;
         if (!run) begin
            per_cnt_reg <= '0;
         end else if (restart || capture) begin
            per_cnt_reg <= period;
         end else begin
            per_cnt_reg <= per_cnt_reg - 24'h000001;
         end
      end
   end

   logic signed [SMP_W-1:0] raw [2];
   logic signed [SMP_W-1:0] corr [2];
   logic signed [SMP_W-1:0] est_v [2];
   logic [MAG_W-1:0]        result_magnitude [2];
   logic [POW_W-1:0]        pw [2];
   asm_result_s             res_reg [2];

   assign raw[0] = sample_a;
   assign raw[1] = sample_b;

   for (genvar g = 0; g < 2; g++) begin : g_ch
      logic signed [EST_W-1:0] est_reg;
      logic [PER_W-1:0]        acc_reg, thr_reg;
      logic [MAG_W-1:0]        pk_reg;

      wire signed [SMP_W:0]   diff    = {raw[g][SMP_W-1], raw[g]}
                                        - {est_v[g][SMP_W-1], est_v[g]};
      wire signed [EST_W-1:0] step    = EST_W'(diff) <<< (BW_MAX - kc);
      wire signed [SMP_W-1:0] mon_s   = dcc_reg[DC_SM] ? corr[g] : raw[g];
      wire [11:0]             acc_in  = (g == 0 && cplx) ? 12'(pw[0]) + 12'(pw[1])
                                                         : 12'(pw[g]);
      wire [PER_W-1:0]        acc_sum = acc_reg + PER_W'(acc_in);
      wire                    above   = result_magnitude[g] > threshold;
      wire [PER_W-1:0]        thr_sum = thr_reg + PER_W'(above);
      wire [MAG_W-1:0]        pk_next = (result_magnitude[g] > pk_reg) ? result_magnitude[g] : pk_reg;

      assign est_v[g] = est_reg[EST_W-1:EST_F];
      assign corr[g]  = sat_of(diff);
      assign result_magnitude[g]   = mag_of(mon_s);
      assign pw[g]    = pow_of(result_magnitude[g]);

      always_ff @(posedge core_clk or negedge resetn) begin
         if (!resetn) begin
            est_reg <= '0;
         end else if (!frz) begin
            est_reg <= est_reg + step;
         end
      end

      always_ff @(posedge core_clk or negedge resetn) begin
         if (!resetn) begin
            acc_reg <= '0;
            thr_reg <= '0;
            pk_reg  <= '0;
         end else begin
            acc_reg <= (!rms_act || restart || capture) ? '0 : acc_sum;
            thr_reg <= (!thr_act || restart || capture) ? '0 : thr_sum;
            pk_reg  <= (!pk_act || restart || capture) ? '0 : pk_next;
         end
      end

      // long counts saturate to the 20-bit result width
      always_ff @(posedge core_clk or negedge resetn) begin
         if (!resetn) begin
            res_reg[g] <= '0;
         end else if (capture) begin
            if (rms_act) res_reg[g].result_magnitude <= {isqrt(acc_sum), 8'h00};
            if (pk_act)  res_reg[g].pk  <= RES_W'(pk_next);
            if (thr_act) res_reg[g].thr <= (thr_sum > 24'h0fffff) ? 20'hfffff
                                                                 : thr_sum[RES_W-1:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         data_out_a <= '0;
         data_out_b <= '0;
      end else begin
         data_out_a <= dcc_reg[DC_PATH] ? corr[0] : raw[0];
         data_out_b <= dcc_reg[DC_PATH] ? corr[1] : raw[1];
      end
   end

   // readback
   wire [RES_W-1:0] sel_a  = pick(res_reg[0], mode);
   wire [RES_W-1:0] sel_b  = pick(res_reg[1], mode);
   wire [9:0]       ofs_a  = cplx ? res_reg[0].result_magnitude[RES_W-1:10] : est_v[0];
   logic [7:0]      rdata_next;

   always_comb begin
      case (reg_addr)
         ADDR_UT_LO:  rdata_next = ut_lo_reg;
         ADDR_UT_HI:  rdata_next = ut_hi_reg;
         ADDR_DCC:    rdata_next = dcc_reg;
         ADDR_OFSA_L: rdata_next = ofs_a[7:0];
         ADDR_OFSA_H: rdata_next = {6'h00, ofs_a[9:8]};
         ADDR_OFSB_L: rdata_next = est_v[1][7:0];
         ADDR_OFSB_H: rdata_next = {6'h00, est_v[1][9:8]};
         ADDR_SSC:    rdata_next = ssc_reg;
         ADDR_MC:     rdata_next = mc_reg;
         ADDR_PER0:   rdata_next = per0_reg;
         ADDR_PER1:   rdata_next = per1_reg;
         ADDR_PER2:   rdata_next = per2_reg;
         ADDR_RESA0:  rdata_next = sel_a[7:0];
         ADDR_RESA1:  rdata_next = sel_a[15:8];
         ADDR_RESA2:  rdata_next = {4'h0, sel_a[19:16]};
         ADDR_RESB0:  rdata_next = sel_b[7:0];
         ADDR_RESB1:  rdata_next = sel_b[15:8];
         ADDR_RESB2:  rdata_next = {4'h0, sel_b[19:16]};
         default:     rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) reg_rdata <= 8'h00;
      else         reg_rdata <= rdata_next;
   end

   // frame buffer; a result that finds the buffer full waits in pend_reg and a
   // later result overwrites it, so very short periods at slow baud drop frames
   asm_frame_s     buf_mem [BUF_DEPTH];
   asm_frame_s     pend_data_reg;
   logic           pend_reg, cap_d_reg;
   logic [PW-1:0]  wr_ptr_reg, rd_ptr_reg;
   logic [PW:0]    fill_reg;
   asm_tx_e        tx_state_reg;
   logic [2:0]     div_cnt_reg;
   logic [FRAME_W-1:0] sh_reg;
   logic [6:0]     bits_reg;

   wire       in_ready  = fill_reg < (PW+1)'(BUF_DEPTH);
   wire       push      = pend_reg && in_ready;
   wire       out_valid = fill_reg != '0;
   wire [2:0] half      = (ssc_reg[SC_DIV +: 2] == 2'h0) ? 3'h1 :
                          ((ssc_reg[SC_DIV +: 2] == 2'h1) ? 3'h2 : 3'h4);
   wire       clk_run   = !ssc_reg[SC_SLEEP] || tx_state_reg != TX_IDLE
                          || out_valid;
   wire       div_end   = div_cnt_reg == (half - 3'h1);
   wire       rise      = clk_run && div_end && !monitor_serial_clock;
   wire       out_ready = rise && tx_state_reg == TX_IDLE;
   wire       pop       = out_valid && out_ready;
   wire [2:0] nfld      = 3'(fld_en[0]) + 3'(fld_en[1]) + 3'(fld_en[2]);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cap_d_reg     <= 1'b0;
         pend_reg      <= 1'b0;
         pend_data_reg <= '0;
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         fill_reg      <= '0;
      end else begin
         cap_d_reg <= capture;
         if (cap_d_reg && ser_on) begin
            pend_reg      <= 1'b1;
            pend_data_reg <= '{a: res_reg[0], b: res_reg[1]};
         end else if (push) begin
            pend_reg <= 1'b0;
         end
         if (push) begin
            buf_mem[wr_ptr_reg] <= pend_data_reg;
            wr_ptr_reg          <= wr_ptr_reg + PW'(1);
         end
         if (pop) rd_ptr_reg <= rd_ptr_reg + PW'(1);
         fill_reg <= fill_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   // serial clock from a divider on core_clk, so it needs no second domain
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         div_cnt_reg          <= 3'h0;
         monitor_serial_clock <= 1'b0;
      end else if (!clk_run) begin
         div_cnt_reg          <= 3'h0;
         monitor_serial_clock <= 1'b0;
      end else if (div_end) begin
         div_cnt_reg          <= 3'h0;
         monitor_serial_clock <= !monitor_serial_clock;
      end else begin
         div_cnt_reg <= div_cnt_reg + 3'h1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_state_reg       <= TX_IDLE;
         monitor_frame_sync <= 1'b0;
         monitor_serial_out <= 1'b0;
         sh_reg             <= '0;
         bits_reg           <= 7'h00;
      end else if (rise) begin
         case (tx_state_reg)
            TX_IDLE: begin
               monitor_serial_out <= 1'b0;
               if (out_valid) begin
                  monitor_frame_sync <= 1'b1;
                  sh_reg             <= pack(buf_mem[rd_ptr_reg], fld_en);
                  bits_reg           <= 7'(nfld * 6'd40);
                  tx_state_reg       <= TX_SYNC;
               end
            end
            TX_SYNC, TX_SEND: begin
               monitor_frame_sync <= 1'b0;
               if (bits_reg != 7'h00) begin
                  monitor_serial_out <= sh_reg[FRAME_W-1];
                  sh_reg             <= sh_reg << 1;
                  bits_reg           <= bits_reg - 7'h01;
                  tx_state_reg       <= TX_SEND;
               end else begin
                  monitor_serial_out <= 1'b0;
                  tx_state_reg       <= TX_IDLE;
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   property p_rms_sel;
      (mon_en && ssc_reg[SC_RMS]) |-> rms_act && (restart || run_d_reg);
   endproperty
   a_rms_sel: assert property (p_rms_sel) else $error("rms mode not selected");
   property p_load;
      restart |=> per_cnt_reg == $past(period);
   endproperty
   a_load: assert property (p_load) else $error("period not loaded on start");
   property p_rms_cap;
      (capture && rms_act && !cplx) |=>
         res_reg[0].result_magnitude == {isqrt($past(g_ch[0].acc_sum)), 8'h00} && g_ch[0].acc_reg == '0;
   endproperty
   a_rms_cap: assert property (p_rms_cap) else $error("rms result wrong");
   property p_thr_sel;
      (mon_en && mode[1]) |-> thr_act;
   endproperty
   a_thr_sel: assert property (p_thr_sel) else $error("threshold mode off");
   property p_thr_inc;
      (thr_act && !restart && !capture && g_ch[0].above) |=>
         g_ch[0].thr_reg == $past(g_ch[0].thr_reg) + 24'h000001;
   endproperty
   a_thr_inc: assert property (p_thr_inc) else $error("count not incremented");
   property p_thr_clr;
      (thr_act && capture) |=> g_ch[0].thr_reg == '0 && per_cnt_reg == $past(period);
   endproperty
   a_thr_clr: assert property (p_thr_clr) else $error("count not cleared");
   property p_off;
      !mon_en |=> per_cnt_reg == '0;
   endproperty
   a_off: assert property (p_off) else $error("monitor runs while disabled");
   property p_freeze;
      frz |=> g_ch[1].est_reg == $past(g_ch[1].est_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("correction moved in freeze");
   property p_path;
      !dcc_reg[DC_PATH] |=> data_out_a == $past(raw[0]);
   endproperty
   a_path: assert property (p_path) else $error("data path altered");
   property p_sleep;
      (ssc_reg[SC_SLEEP] && tx_state_reg == TX_IDLE && !out_valid) |=> !monitor_serial_clock;
   endproperty
   a_sleep: assert property (p_sleep) else $error("serial clock runs in sleep");
   property p_sync_one;
      (tx_state_reg == TX_SYNC && rise) |=> !monitor_frame_sync && $rose(monitor_serial_clock);
   endproperty
   a_sync_one: assert property (p_sync_one) else $error("frame sync too long");
   property p_msb;
      (tx_state_reg == TX_SYNC && rise && bits_reg != 7'h00) |=>
         monitor_serial_out == $past(sh_reg[FRAME_W-1]);
   endproperty
   a_msb: assert property (p_msb) else $error("first bit not msb");
   property p_resync;
      (run && run_d_reg && sync_rise) |=> per_cnt_reg == $past(period);
   endproperty
   a_resync: assert property (p_resync) else $error("sync did not restart");

   c_rms_cap: cover property (capture && rms_act);
   c_thr_cap: cover property (capture && thr_act && g_ch[0].thr_sum != '0);
   c_frame:   cover property ($rose(monitor_frame_sync));
   c_resync:  cover property (run && run_d_reg && sync_rise);

endmodule : asm_monitor
`default_nettype wire

/* File: dv/asm_frame_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module asm_frame_rx #(
   parameter int NBITS = 40
) (
   input  wire logic             ser_clk,
   input  wire logic             frame_sync,
   input  wire logic             ser_data,
   output logic [NBITS-1:0]      frame,
   output int                    frames
);
   logic [NBITS-1:0] shift_reg;
   int               left;
   initial begin
      frames = 0;
      left = 0;
      frame = '0;
   end
   // only samples; falling edge keeps clear of the rising launch edge
   always @(negedge ser_clk) begin
      if (frame_sync) begin
         left = NBITS;
      end else if (left > 0) begin
         shift_reg = {shift_reg[NBITS-2:0], ser_data};
         left = left - 1;
         if (left == 0) begin
            frame = shift_reg;
            frames = frames + 1;
         end
      end
   end
endmodule : asm_frame_rx
`default_nettype wire

/* File: dv/tb_asm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_asm_monitor;
   import asm_pkg::*;
   logic              core_clk = 0, resetn = 0, sync_in = 0, reg_wr_en = 0;
   logic [8:0]        reg_addr = 9'h0;
   logic [7:0]        reg_wdata = 8'h0, reg_rdata;
   logic signed [9:0] sample_a = 10'sd100, sample_b = -10'sd5;
   logic signed [9:0] data_out_a, data_out_b;
   logic              monitor_serial_clock, monitor_frame_sync, monitor_serial_out;
   logic [39:0]       frame;
   int                frames, bad_count = 0, cmp_count = 0;
   always #12.5 core_clk = ~core_clk;
   asm_monitor u_asm_monitor (.core_clk, .resetn, .sample_a, .sample_b, .sync_in,
      .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .data_out_a, .data_out_b,
      .monitor_serial_clock, .monitor_frame_sync, .monitor_serial_out);
   asm_frame_rx u_asm_frame_rx (.ser_clk(monitor_serial_clock),
      .frame_sync(monitor_frame_sync), .ser_data(monitor_serial_out), .frame, .frames);
   task close_out;
      $display("mismatches %0d compares %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   task chk(string n, logic [39:0] seen, logic [39:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s exp %0h seen %0h", n, exp, seen);
      end
   endtask : chk
   task cyc(int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task wr(logic [8:0] a, logic [7:0] d);
      @(posedge core_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr_en <= 1'b0;
   endtask : wr
   task rd(logic [8:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      cyc(2);
      #1 d = reg_rdata;
   endtask : rd
   task rd24(logic [8:0] a, output logic [23:0] v);
      logic [7:0] b0, b1, b2;
      rd(a, b0);
      rd(a + 9'h1, b1);
      rd(a + 9'h2, b2);
      v = {b2, b1, b0};
   endtask : rd24
   initial begin
      logic [7:0]  b, o;
      logic [23:0] v;
      int          i;
      cyc(5);
      resetn <= 1'b1;
      rd(ADDR_PER0, b); chk("per0", b, 8'h80);
      rd(ADDR_MC, b); chk("mc", b, 8'h00);
      rd(9'h11c, b); chk("unmapped", b, 8'h00);
      chk("path_a", data_out_a, sample_a);
      chk("path_b", data_out_b, sample_b);
      wr(ADDR_UT_HI, 8'hff);
      rd(ADDR_UT_HI, b); chk("ut_hi", b, 8'h1f);
      wr(ADDR_UT_HI, 8'h02);
      wr(ADDR_UT_LO, 8'h00);
      // mode bits alone do nothing while the block is off
      wr(ADDR_MC, 8'h04); cyc(400);
      rd24(ADDR_RESA0, v); chk("off", v, 24'h0);
      wr(ADDR_MC, 8'h05); cyc(400);
      rd24(ADDR_RESA0, v); chk("thr_a", v, 24'd128);
      rd24(ADDR_RESB0, v); chk("thr_b", v, 24'h0);
      wr(ADDR_MC, 8'h01); cyc(400);
      rd24(ADDR_RESA0, v); chk("rms_a", v, 24'h004600);
      wr(ADDR_MC, 8'h04);
      wr(ADDR_PER1, 8'h02);
      wr(ADDR_PER0, 8'h00);
      wr(ADDR_MC, 8'h05);
      wr(ADDR_SSC, 8'h65);
      for (i = 0; i < 4000 && frames < 2; i++) cyc(1);
      // a missing frame counts as a mismatch and the run goes on to the verdict
      if (frames < 2) bad_count++;
      else chk("frame", frame, {20'd512, 20'd0});
      cyc(20);
      for (i = 0; i < 8; i++) begin
         cyc(1);
         #1 chk("sleep", monitor_serial_clock, 40'h0);
      end
      // complex power: A reports both channels, B keeps its own magnitude
      wr(ADDR_MC, 8'h09);
      sample_b <= -10'sd100;
      cyc(1100);
      rd24(ADDR_RESA0, v); chk("cplx_a", v, 24'h00c700);
      rd24(ADDR_RESB0, v); chk("cplx_b", v, 24'h008d00);
      rd(ADDR_OFSA_L, b); chk("cplx_ofs", b, 8'h31);
      wr(ADDR_MC, 8'h04);
      wr(ADDR_PER1, 8'h00);
      wr(ADDR_PER0, 8'h80);
      wr(ADDR_MC, 8'h05);
      cyc(60);
      sync_in <= 1'b1;
      cyc(4);
      sync_in <= 1'b0;
      // the restarted period has not ended yet, so the old count still shows
      cyc(86);
      rd24(ADDR_RESA0, v); chk("resync_old", v, 24'd512);
      cyc(40);
      rd24(ADDR_RESA0, v); chk("resync_new", v, 24'd128);
      wr(ADDR_MC, 8'h03);
      cyc(300);
      rd24(ADDR_RESA0, v); chk("peak", v, 24'h000320);
      wr(ADDR_DCC, 8'h40);
      rd(ADDR_OFSA_L, b);
      rd(ADDR_OFSA_H, o); chk("ofs_a_hi", o, 8'h00);
      rd(ADDR_OFSB_H, o); chk("ofs_b_hi", o, 8'h03);
      cyc(50);
      rd(ADDR_OFSA_L, o); chk("freeze", o, b);
      wr(ADDR_DCC, 8'h42);
      cyc(2);
      #1 chk("path_on", data_out_a, 10'd100 - b);
      close_out;
   end
endmodule : tb_asm_monitor
`default_nettype wire
